/* bench/hkd_line_model.sv */
// Behavioural microphone line with a key resistor network behind it.
// Assumes the bench drives press and key_code just after a rising edge of ref_clk.
module hkd_line_model (
  // Clock
  input  wire logic       ref_clk,
  // Key control from the bench
  input  wire logic       press,
  input  wire logic [7:0] key_code,
  // Line seen by the detector
  output logic            line_below_thresh,
  output logic [7:0]      line_code
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] idle_code_q;

  // A released key leaves no valid code, so the idle value keeps changing.
  always_ff @(posedge ref_clk) begin
    idle_code_q <= press ? ~key_code : ~idle_code_q;
  end

  // The comparator reacts to the line at once; the code holds while pressed.
  assign line_below_thresh = press;
  assign line_code         = press ? key_code : idle_code_q;
endmodule : hkd_line_model

/* bench/tb_top.sv */
// Self-checking bench for the headset key press detector.
// Assumes hkd_pkg is compiled first and hkd_regs.svh is on the include path.
`include "hkd_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                ref_clk = 1'b0;
  logic                reset;
  hkd_pkg::hkd_cfg_s   cfg;
  hkd_pkg::hkd_switch_s sw;
  logic                accessory_removed;
  logic                flags_read;
  logic                press;
  logic [7:0]          key_code;
  logic                line_below_thresh;
  logic [7:0]          line_code;
  hkd_pkg::hkd_flags_s flags;
  logic                key_irq_n;
  logic                mic_on_sleeve;
  logic                config_valid;
  int                  n_fail = 0;
  int                  check_count = 0;
  logic [7:0]          codes [4] = '{8'h0F, 8'h10, 8'h2F, 8'h30};

  always #4 ref_clk = ~ref_clk;

  hkd_line_model hkd_line_model_i (.ref_clk(ref_clk), .press(press), .key_code(key_code),
    .line_below_thresh(line_below_thresh), .line_code(line_code));

  hkd_key_detector hkd_key_detector_i (.ref_clk(ref_clk), .reset(reset), .cfg(cfg), .sw(sw),
    .accessory_removed(accessory_removed), .line_below_thresh(line_below_thresh),
    .line_code(line_code), .flags_read(flags_read), .flags(flags), .key_irq_n(key_irq_n),
    .mic_on_sleeve(mic_on_sleeve), .config_valid(config_valid));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic chk_flags(input logic [7:0] exp, input logic exp_irq_n, input string what);
    check_count++;
    if (flags !== exp || key_irq_n !== exp_irq_n) begin
      n_fail++;
      $display("BAD %0t %s flags=%h irq_n=%b", $time, what, flags, key_irq_n);
    end
  endtask : chk_flags

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got=%b", $time, what, got);
    end
  endtask : chk_bit

  // Waits a bounded time for the flags to move; a hang shows in the next compare.
  task automatic wait_change();
    logic [7:0] old;
    old = flags;
    for (int i = 0; i < 400 && flags === old; i++) tick(1);
  endtask : wait_change

  task automatic hit(input logic [7:0] code);
    key_code = code;
    press = 1'b1;
    wait_change();
  endtask : hit

  task automatic lift();
    press = 1'b0;
    wait_change();
  endtask : lift

  task automatic read_clear();
    flags_read = 1'b1;
    tick(1);
    flags_read = 1'b0;
    tick(1);
  endtask : read_clear

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    #400000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    reset = 1'b1;
    cfg = '0;
    cfg.mic_bias_code = `HKD_BIAS_REF;
    cfg.bin_boundary_1 = `HKD_BIN1_DEFAULT;
    cfg.bin_boundary_2 = `HKD_BIN2_DEFAULT;
    cfg.bin_boundary_3 = `HKD_BIN3_DEFAULT;
    sw = hkd_pkg::hkd_switch_s'(4'h6);
    accessory_removed = 1'b0;
    flags_read = 1'b0;
    press = 1'b0;
    key_code = 8'h00;
    tick(8);
    reset = 1'b0;
    tick(2);
    chk_bit(mic_on_sleeve, 1'b1, "sleeve pattern");
    chk_bit(config_valid, 1'b1, "sleeve valid");
    press = 1'b1;
    tick(200);
    chk_flags(8'h00, 1'b1, "idle while disabled");
    press = 1'b0;
    tick(4);
    cfg.detect_enable = 1'b1;
    $display("test disabled done");
    for (int k = 0; k < 4; k++) begin
      hit(codes[k]);
      chk_flags(8'h01 << k, 1'b0, "press flag");
      lift();
      chk_flags(8'h11 << k, 1'b0, "release flag");
      read_clear();
      chk_flags(8'h00, 1'b1, "read clears");
    end
    $display("test bins done");
    sw = hkd_pkg::hkd_switch_s'(4'h9);
    tick(2);
    chk_bit(mic_on_sleeve, 1'b0, "ring2 pattern");
    chk_bit(config_valid, 1'b1, "ring2 valid");
    hit(codes[0]);
    lift();
    hit(codes[1]);
    lift();
    hit(codes[0]);
    chk_flags(8'h23, 1'b0, "unread sequence");
    read_clear();
    lift();
    chk_flags(8'h10, 1'b0, "release after read");
    read_clear();
    $display("test unread done");
    key_code = codes[2];
    press = 1'b1;
    tick(100);
    press = 1'b0;
    tick(1);
    press = 1'b1;
    tick(120);
    chk_flags(8'h00, 1'b1, "glitch restarts");
    wait_change();
    chk_flags(8'h04, 1'b0, "steady press");
    cfg.detect_enable = 1'b0;
    tick(2);
    chk_flags(8'h00, 1'b1, "disable clears");
    press = 1'b0;
    tick(4);
    cfg.detect_enable = 1'b1;
    hit(codes[3]);
    chk_flags(8'h08, 1'b0, "press before removal");
    accessory_removed = 1'b1;
    tick(1);
    accessory_removed = 1'b0;
    tick(1);
    chk_flags(8'h00, 1'b1, "removal clears");
    press = 1'b0;
    tick(300);
    read_clear();
    $display("test clearing done");
    cfg.press_deb_units = 8'h01;
    key_code = codes[0];
    press = 1'b1;
    tick(200);
    chk_flags(8'h00, 1'b1, "press inside longer debounce");
    wait_change();
    chk_flags(8'h01, 1'b0, "press after longer debounce");
    lift();
    read_clear();
    cfg.press_deb_units = 8'h00;
    $display("test long debounce done");
    cfg.mic_bias_code = 4'h4;
    tick(1);
    hit(8'h0C);
    chk_flags(8'h02, 1'b0, "bias scaled bin");
    lift();
    read_clear();
    sw = hkd_pkg::hkd_switch_s'(4'hF);
    tick(2);
    chk_bit(config_valid, 1'b0, "bad pattern");
    press = 1'b1;
    tick(200);
    chk_flags(8'h00, 1'b1, "no detect bad pattern");
    press = 1'b0;
    $display("test bias and switches done");
    wrap_up();
  end
endmodule : tb_top

/* include/hkd_pkg.sv */
// Types shared by the headset key press detector files.
// Assumes hkd_regs.svh holds the numeric constants.
package hkd_pkg;

  typedef enum logic [1:0] {
    HKD_IDLE,
    HKD_PRESS_DEB,
    HKD_HELD,
    HKD_RELEASE_DEB
  } hkd_state_e;

  typedef struct packed {
    logic       detect_enable;
    logic [3:0] mic_bias_code;
    logic [7:0] press_deb_units;
    logic [7:0] release_deb_units;
    logic [7:0] bin_boundary_1;
    logic [7:0] bin_boundary_2;
    logic [7:0] bin_boundary_3;
  } hkd_cfg_s;

  typedef struct packed {
    logic mic_path_ring2_switch;
    logic mic_path_sleeve_switch;
    logic gnd_path_ring2_switch;
    logic gnd_path_sleeve_switch;
  } hkd_switch_s;

  typedef struct packed {
    logic [3:0] release_flag;
    logic [3:0] press_flag;
  } hkd_flags_s;

endpackage : hkd_pkg

/* include/hkd_regs.svh */
// Constants for the headset key press detector: thresholds, timing and flag layout.
// Assumes a 125 MHz ref_clk and an 8-bit resistance code from the line converter.
`ifndef HKD_REGS_SVH
`define HKD_REGS_SVH

`define HKD_NUM_KEYS          4
`define HKD_OHM_PER_LSB       6
`define HKD_BIN1_DEFAULT      8'h10
`define HKD_BIN2_DEFAULT      8'h20
`define HKD_BIN3_DEFAULT      8'h30
`define HKD_BIAS_REF          4'h8
`define HKD_CLK_PERIOD_NS     8
`define HKD_DEB_UNIT_US       1
`define HKD_DEB_UNIT_CYC      ((`HKD_DEB_UNIT_US * 1000) / `HKD_CLK_PERIOD_NS)
`define HKD_PRESS_FLAG_LSB    0
`define HKD_RELEASE_FLAG_LSB  4

`endif

/* verilog/hkd_debounce_timer.sv */
// Debounce timer: counts time units while a level stays steady.
// Assumes the level is already synchronised to ref_clk.
`include "hkd_regs.svh"
module hkd_debounce_timer (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Control
  input  wire logic       run,
  input  wire logic [7:0] limit_units,
  // Result
  output logic            expired
);

  typedef struct packed {
    logic [15:0] cyc;
    logic [8:0]  units;
    logic        expired;
  } hkd_tmr_s;

  hkd_tmr_s st_q;
  hkd_tmr_s st_d;

  // Any drop of run restarts the count, so a glitch never lets time accumulate.
  always_comb begin
    st_d = st_q;
    if (!run) begin
      st_d = '0;
    end else if (!st_q.expired) begin
      // The spare bit of units lets a limit of FFh still expire instead of wrapping to zero.
      if (st_q.units > {1'b0, limit_units}) begin
        st_d.expired = 1'b1;
      end else if (st_q.cyc == 16'(`HKD_DEB_UNIT_CYC - 1)) begin
        st_d.cyc   = '0;
        st_d.units = st_q.units + 9'h001;
      end else begin
        st_d.cyc = st_q.cyc + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expired = st_q.expired;

endmodule : hkd_debounce_timer

/* verilog/hkd_key_detector.sv */
// Headset key press detector: debounces the microphone line, bins keys, keeps flags.
// Assumes line_below_thresh comes from an analog comparator (asynchronous) and
// line_code is a resistance code from a converter, stable while the line is low.
`include "hkd_regs.svh"

// Functional notes
// [R01] Monitoring stays idle until the host sets the detection enable bit.
// [R02] Host applies mic bias to the bias input before enabling detection.
// [R03] Mic location comes from switch state; only two switch patterns supported.
// [R04] A press is valid only after the line stays low past press debounce.
// [R05] Any return above threshold restarts the press debounce timer.
// [R06] Valid press sets press flag, clears release flag, asserts interrupt.
// [R07] Release past release debounce sets the release flag and asserts interrupt.
// [R08] Flags return to zero on disable or accessory removal.
// [R09] Clearing enable mid-detection halts at once and clears all flags.
// [R10] Host read of the flags clears them and releases the interrupt.
// [R11] Detection keeps running while earlier flags remain unread.
// [R12] Four keys, each with its own press and release flag.
// [R13] Bin boundaries are 6 ohm codes; first defaults to 10h, 96 ohms.
// [R14] The mic-bias setting scales the detection thresholds.
// [R15] Host programs the bias setting at or above the actual bias output.
// [R16] Host reads press plus release as one press, press only as held.
// [R17] Host treats a long-held key as held until its release is read.
// [R18] Interrupt stays low while any flag is set, high when all clear.
module hkd_key_detector (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // Configuration from the host
  input  wire hkd_pkg::hkd_cfg_s  cfg,
  input  wire hkd_pkg::hkd_switch_s sw,
  // Accessory and line
  input  wire logic               accessory_removed,
  input  wire logic               line_below_thresh,
  input  wire logic [7:0]         line_code,
  // Host flag read
  input  wire logic               flags_read,
  // Results
  output hkd_pkg::hkd_flags_s     flags,
  output logic                    key_irq_n,
  output logic                    mic_on_sleeve,
  output logic                    config_valid
);

  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic [7:0]           code_s1;
    logic [7:0]           code_s2;
    hkd_pkg::hkd_state_e  state;
    logic [1:0]           key;
    hkd_pkg::hkd_flags_s  flags;
    logic                 irq_n;
    logic                 on_sleeve;
    logic                 cfg_ok;
  } hkd_det_s;

  hkd_det_s   st_q;
  hkd_det_s   st_d;
  logic       press_done;
  logic       release_done;
  logic       ring2_ok;
  logic       sleeve_ok;
  logic [11:0] b1;
  logic [11:0] b2;
  logic [11:0] b3;
  logic [11:0] code_scaled;

  assign ring2_ok  = sw.mic_path_ring2_switch && !sw.mic_path_sleeve_switch
                   && !sw.gnd_path_ring2_switch && sw.gnd_path_sleeve_switch; // [R03]
  assign sleeve_ok = !sw.mic_path_ring2_switch && sw.mic_path_sleeve_switch
                   && sw.gnd_path_ring2_switch && !sw.gnd_path_sleeve_switch; // [R03]

  // Boundaries scale with the bias code; a code of HKD_BIAS_REF leaves them as programmed.
  assign b1 = 12'(cfg.bin_boundary_1) * 12'(cfg.mic_bias_code); // [R14] [R13]
  assign b2 = 12'(cfg.bin_boundary_2) * 12'(cfg.mic_bias_code); // [R14]
  assign b3 = 12'(cfg.bin_boundary_3) * 12'(cfg.mic_bias_code); // [R14]
  assign code_scaled = 12'(st_q.code_s2) * 12'(`HKD_BIAS_REF);

  hkd_debounce_timer u_press_tmr (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .run         (st_q.state == hkd_pkg::HKD_PRESS_DEB && st_q.sync2), // [R05]
    .limit_units (cfg.press_deb_units),
    .expired     (press_done)
  );

  hkd_debounce_timer u_release_tmr (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .run         (st_q.state == hkd_pkg::HKD_RELEASE_DEB && !st_q.sync2),
    .limit_units (cfg.release_deb_units),
    .expired     (release_done)
  );

  always_comb begin
    st_d           = st_q;
    st_d.sync1     = line_below_thresh;
    st_d.sync2     = st_q.sync1;
    // The code word has no handshake; it is only used after a full debounce of steady line.
    st_d.code_s1   = line_code;
    st_d.code_s2   = st_q.code_s1;
    st_d.cfg_ok    = ring2_ok || sleeve_ok;
    st_d.on_sleeve = sleeve_ok;
    // A read clears what was there; a flag set this same cycle survives below.
    if (flags_read) begin
      st_d.flags = '0; // [R10]
    end
    if (!cfg.detect_enable || accessory_removed) begin
      st_d.state = hkd_pkg::HKD_IDLE; // [R09] [R01]
      st_d.flags = '0;                // [R08]
    end else begin
      case (st_q.state)
        hkd_pkg::HKD_IDLE: begin
          if (st_q.sync2 && st_q.cfg_ok) begin
            st_d.state = hkd_pkg::HKD_PRESS_DEB;
          end
        end
        hkd_pkg::HKD_PRESS_DEB: begin
          if (!st_q.sync2) begin
            st_d.state = hkd_pkg::HKD_IDLE; // [R05]
          end else if (press_done) begin // [R04]
            if (code_scaled < b1) begin
              st_d.key = 2'h0;
            end else if (code_scaled < b2) begin
              st_d.key = 2'h1;
            end else if (code_scaled < b3) begin
              st_d.key = 2'h2;
            end else begin
              st_d.key = 2'h3; // [R12]
            end
            st_d.state = hkd_pkg::HKD_HELD;
          end
        end
        hkd_pkg::HKD_HELD: begin
          if (!st_q.sync2) begin
            st_d.state = hkd_pkg::HKD_RELEASE_DEB;
          end
        end
        default: begin
          if (st_q.sync2) begin
            st_d.state = hkd_pkg::HKD_HELD;
          end else if (release_done) begin
            st_d.state = hkd_pkg::HKD_IDLE;
          end
        end
      endcase
      // Flag updates override the read clear, and run regardless of unread flags.
      if (st_q.state == hkd_pkg::HKD_PRESS_DEB && st_d.state == hkd_pkg::HKD_HELD) begin
        st_d.flags.press_flag[st_d.key]   = 1'b1; // [R06] [R11]
        st_d.flags.release_flag[st_d.key] = 1'b0; // [R06]
      end
      if (st_q.state == hkd_pkg::HKD_RELEASE_DEB && release_done && !st_q.sync2) begin
        st_d.flags.release_flag[st_q.key] = 1'b1; // [R07] [R11]
      end
    end
    st_d.irq_n = (st_d.flags == '0); // [R18]
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q       <= '0;
      st_q.state <= hkd_pkg::HKD_IDLE;
      st_q.irq_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags         = st_q.flags;
  assign key_irq_n     = st_q.irq_n;
  assign mic_on_sleeve = st_q.on_sleeve;
  assign config_valid  = st_q.cfg_ok;

  chk_disable_clears: assert property (@(posedge ref_clk) disable iff (reset)
    !cfg.detect_enable |=> flags == '0 && key_irq_n) // [R09]
    else $error("flags not cleared after disable");
  chk_removal_clears: assert property (@(posedge ref_clk) disable iff (reset)
    accessory_removed |=> flags == '0) // [R08]
    else $error("flags not cleared after removal");
  chk_irq_tracks_flags: assert property (@(posedge ref_clk) disable iff (reset)
    key_irq_n == (flags == '0)) // [R18]
    else $error("interrupt does not match flags");
  chk_no_flag_idle: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(|flags.press_flag) |-> $past(cfg.detect_enable)) // [R01]
    else $error("press flag set while disabled");
  chk_press_needs_deb: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(st_q.state == hkd_pkg::HKD_HELD) && $past(st_q.state) == hkd_pkg::HKD_PRESS_DEB
    |-> $past(press_done) && $past(st_q.sync2)) // [R04]
    else $error("press accepted before debounce");
  chk_glitch_restart: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.state == hkd_pkg::HKD_PRESS_DEB && !st_q.sync2 && cfg.detect_enable
    && !accessory_removed |=> st_q.state == hkd_pkg::HKD_IDLE) // [R05]
    else $error("glitch did not restart press debounce");
  chk_press_clr_rel: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.state == hkd_pkg::HKD_PRESS_DEB && st_d.state == hkd_pkg::HKD_HELD
    |=> flags.press_flag[st_q.key] && !flags.release_flag[st_q.key] && !key_irq_n) // [R06]
    else $error("press flag update wrong");
  chk_release_sets: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.state == hkd_pkg::HKD_RELEASE_DEB && release_done && !st_q.sync2
    && cfg.detect_enable && !accessory_removed
    |=> flags.release_flag[$past(st_q.key)] && !key_irq_n) // [R07]
    else $error("release flag not set");
  chk_read_clears: assert property (@(posedge ref_clk) disable iff (reset)
    flags_read && st_q.state == hkd_pkg::HKD_IDLE |=> flags == '0) // [R10]
    else $error("read did not clear flags");
  chk_bad_switch: assert property (@(posedge ref_clk) disable iff (reset)
    !config_valid && st_q.state == hkd_pkg::HKD_IDLE |=> st_q.state == hkd_pkg::HKD_IDLE) // [R03]
    else $error("detection started with unsupported switches");
  chk_first_bin_key: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.state == hkd_pkg::HKD_PRESS_DEB && st_d.state == hkd_pkg::HKD_HELD
    && code_scaled < b1 |=> st_q.key == 2'h0) // [R13]
    else $error("code below first boundary not sorted to first key");

  cov_press: cover property (@(posedge ref_clk) $rose(|flags.press_flag));
  cov_release: cover property (@(posedge ref_clk) $rose(|flags.release_flag));
  cov_glitch: cover property (@(posedge ref_clk)
    st_q.state == hkd_pkg::HKD_PRESS_DEB ##1 st_q.state == hkd_pkg::HKD_IDLE);
  cov_two_keys: cover property (@(posedge ref_clk) $countones(flags.press_flag) >= 2);
  cov_press_over_unread: cover property (@(posedge ref_clk)
    st_q.state == hkd_pkg::HKD_PRESS_DEB && st_d.state == hkd_pkg::HKD_HELD && flags != '0);

endmodule : hkd_key_detector
